// >>> pbcd_port.sv
// Port B general-purpose I/O with per-pin change detection.
// Assumes an AXI4-Lite master and external pad logic that resolves pins.
module pbcd_port
  import pbcd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        power_on_reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_pin_in,
  output logic      [7:0]  port_pin_out,
  output logic      [7:0]  port_pin_oe,
  output logic      [7:0]  port_pullup_on,
  output logic      [5:0]  analog_select_bits,
  output logic             change_irq,
  output logic             wake_request
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic [7:0]  out_latch;
    logic [7:0]  direction;
    logic [7:0]  pullup_en;
    logic [7:0]  change_en;
    logic [5:0]  analog_sel;
    logic [7:0]  intctrl;
    logic [7:0]  option;
  } pbcd_port_type;

  pbcd_port_type state;
  pbcd_port_type next_state;

  // Snapshot latch lives outside the main reset (kept through master clear)
  logic [7:0] snapshot;
  logic [7:0] next_snapshot;

  logic [7:0] pin_sync;
  logic [7:0] analog_mask;
  logic [7:0] pin_read;
  logic [7:0] mismatch;
  logic       any_mismatch;
  logic       do_write;
  logic       do_read;
  logic       data_access;
  logic [7:0] wbyte;
  logic       wr_sel_data;
  logic       wr_sel_direction;
  logic       wr_sel_pullup;
  logic       wr_sel_change_en;
  logic       wr_sel_analog;
  logic       wr_sel_intctrl;
  logic       wr_sel_option;
  logic       wr_mapped;
  logic       rd_sel_data;
  logic       rd_sel_direction;
  logic       rd_sel_pullup;
  logic       rd_sel_change_en;
  logic       rd_sel_analog;
  logic       rd_sel_intctrl;
  logic       rd_sel_option;
  logic       rd_mapped;

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  pbcd_sync u_sync (
    .sys_clk  (sys_clk),
    .async_in (port_pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------------
  // Pin datapath
  // ----------------------------------------------------------------------
  assign analog_mask = {2'b00, state.analog_sel};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pin_read[gi] = pin_sync[gi] & ~analog_mask[gi];
      assign mismatch[gi] = state.change_en[gi] & ~analog_mask[gi]
                          & (pin_read[gi] ^ snapshot[gi]);
      assign port_pin_oe[gi] = ~state.direction[gi];
      assign port_pullup_on[gi] = state.pullup_en[gi]
        & ~state.option[PBCD_BIT_PULLUP_DIS]
        & state.direction[gi]
        & ~analog_mask[gi];
    end
  endgenerate

  assign any_mismatch       = |mismatch;
  assign port_pin_out       = state.out_latch;
  assign analog_select_bits = state.analog_sel;

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~state.aw_held & ~state.b_valid;
  assign s_axi_wready  = ~state.w_held & ~state.b_valid;
  assign s_axi_arready = ~state.r_valid;
  assign s_axi_bvalid  = state.b_valid;
  assign s_axi_bresp   = state.b_resp;
  assign s_axi_rvalid  = state.r_valid;
  assign s_axi_rdata   = state.r_data;
  assign s_axi_rresp   = state.r_resp;

  assign do_write = state.aw_held & state.w_held & ~state.b_valid;
  assign do_read  = s_axi_arvalid & ~state.r_valid;
  assign wbyte    = state.w_data[7:0];
  assign data_access = (do_write & wr_sel_data)
                     | (do_read & rd_sel_data);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Held write address and live read address, one select per register
  assign wr_sel_data      = state.aw_addr == PBCD_OFF_DATA;
  assign wr_sel_direction = state.aw_addr == PBCD_OFF_DIRECTION;
  assign wr_sel_pullup    = state.aw_addr == PBCD_OFF_PULLUP;
  assign wr_sel_change_en = state.aw_addr == PBCD_OFF_CHANGE_EN;
  assign wr_sel_analog    = state.aw_addr == PBCD_OFF_ANALOG;
  assign wr_sel_intctrl   = state.aw_addr == PBCD_OFF_INTCTRL;
  assign wr_sel_option    = state.aw_addr == PBCD_OFF_OPTION;
  assign wr_mapped        = wr_sel_data | wr_sel_direction | wr_sel_pullup
                          | wr_sel_change_en | wr_sel_analog | wr_sel_intctrl
                          | wr_sel_option;

  assign rd_sel_data      = s_axi_araddr == PBCD_OFF_DATA;
  assign rd_sel_direction = s_axi_araddr == PBCD_OFF_DIRECTION;
  assign rd_sel_pullup    = s_axi_araddr == PBCD_OFF_PULLUP;
  assign rd_sel_change_en = s_axi_araddr == PBCD_OFF_CHANGE_EN;
  assign rd_sel_analog    = s_axi_araddr == PBCD_OFF_ANALOG;
  assign rd_sel_intctrl   = s_axi_araddr == PBCD_OFF_INTCTRL;
  assign rd_sel_option    = s_axi_araddr == PBCD_OFF_OPTION;
  assign rd_mapped        = rd_sel_data | rd_sel_direction | rd_sel_pullup
                          | rd_sel_change_en | rd_sel_analog | rd_sel_intctrl
                          | rd_sel_option;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (s_axi_awvalid & s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (state.b_valid & s_axi_bready) begin
      next_state.b_valid = 1'b0;
    end
    if (state.r_valid & s_axi_rready) begin
      next_state.r_valid = 1'b0;
    end
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.b_valid = 1'b1;
      next_state.b_resp  = wr_mapped ? PBCD_RESP_OKAY : PBCD_RESP_SLVERR;
      if (state.w_strb[0]) begin
        case (state.aw_addr)
          PBCD_OFF_DATA: begin
            // Whole-byte write into the latch; no pin read is merged in
            next_state.out_latch = wbyte;
          end
          PBCD_OFF_DIRECTION: begin
            next_state.direction = wbyte;
          end
          PBCD_OFF_PULLUP: begin
            next_state.pullup_en = wbyte;
          end
          PBCD_OFF_CHANGE_EN: begin
            next_state.change_en = wbyte;
          end
          PBCD_OFF_ANALOG: begin
            next_state.analog_sel = wbyte[5:0];
          end
          PBCD_OFF_INTCTRL: begin
            next_state.intctrl = wbyte;
          end
          PBCD_OFF_OPTION: begin
            next_state.option = wbyte;
          end
          default: begin
            next_state.b_resp = PBCD_RESP_SLVERR;
          end
        endcase
      end else begin
        case (state.aw_addr)
          PBCD_OFF_DATA, PBCD_OFF_DIRECTION, PBCD_OFF_PULLUP,
          PBCD_OFF_CHANGE_EN, PBCD_OFF_ANALOG, PBCD_OFF_INTCTRL,
          PBCD_OFF_OPTION: begin
            next_state.b_resp = PBCD_RESP_OKAY;
          end
          default: begin
            next_state.b_resp = PBCD_RESP_SLVERR;
          end
        endcase
      end
    end
    if (do_read) begin
      next_state.r_valid = 1'b1;
      next_state.r_resp  = rd_mapped ? PBCD_RESP_OKAY : PBCD_RESP_SLVERR;
      next_state.r_data  = 32'h0000_0000;
      case (s_axi_araddr)
        PBCD_OFF_DATA: begin
          next_state.r_data[7:0] = pin_read;
        end
        PBCD_OFF_DIRECTION: begin
          next_state.r_data[7:0] = state.direction;
        end
        PBCD_OFF_PULLUP: begin
          next_state.r_data[7:0] = state.pullup_en;
        end
        PBCD_OFF_CHANGE_EN: begin
          next_state.r_data[7:0] = state.change_en;
        end
        PBCD_OFF_ANALOG: begin
          next_state.r_data[7:0] = {2'b00, state.analog_sel};
        end
        PBCD_OFF_INTCTRL: begin
          next_state.r_data[7:0] = state.intctrl;
        end
        PBCD_OFF_OPTION: begin
          next_state.r_data[7:0] = state.option;
        end
        default: begin
          next_state.r_resp = PBCD_RESP_SLVERR;
        end
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (any_mismatch) begin
      next_state.intctrl[PBCD_BIT_CHANGE_FLAG] = 1'b1;
    end
  end

  // Port access reloads the snapshot; the compare sees the old one until then
  always_comb begin
    next_snapshot = snapshot;
    if (data_access) begin
      next_snapshot = pin_read;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state.aw_held <= 1'b0;
      state.aw_addr <= 8'h00;
      state.w_held  <= 1'b0;
      state.w_data  <= 32'h0000_0000;
      state.w_strb  <= 4'h0;
      state.b_valid <= 1'b0;
      state.b_resp  <= PBCD_RESP_OKAY;
      state.r_valid <= 1'b0;
      state.r_data  <= 32'h0000_0000;
      state.r_resp  <= PBCD_RESP_OKAY;
      state.out_latch  <= state.out_latch;
      state.direction  <= PBCD_RST_DIRECTION;
      state.pullup_en  <= PBCD_RST_PULLUP;
      state.change_en  <= PBCD_RST_CHANGE_EN;
      state.analog_sel <= PBCD_RST_ANALOG;
      state.intctrl    <= PBCD_RST_INTCTRL;
      state.option     <= PBCD_RST_OPTION;
    end else begin
      state <= next_state;
    end
  end

  // Only power-on reset clears the snapshot
  always_ff @(posedge sys_clk) begin
    if (!power_on_reset_n) begin
      snapshot <= PBCD_RST_LATCH;
    end else begin
      snapshot <= next_snapshot;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and wake
  // ----------------------------------------------------------------------
  assign change_irq = state.intctrl[PBCD_BIT_CHANGE_FLAG]
                    & state.intctrl[PBCD_BIT_CHANGE_IRQ_EN]
                    & state.intctrl[PBCD_BIT_GLOBAL_IRQ_EN];
  assign wake_request = state.intctrl[PBCD_BIT_CHANGE_FLAG]
                      & state.intctrl[PBCD_BIT_CHANGE_IRQ_EN];

endmodule

// >>> pbcd_pkg.sv
// Package for the port B change-detect I/O block: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and eight port pins.
package pbcd_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] PBCD_OFF_DATA      = 8'h00;
  localparam logic [7:0] PBCD_OFF_DIRECTION = 8'h04;
  localparam logic [7:0] PBCD_OFF_PULLUP    = 8'h08;
  localparam logic [7:0] PBCD_OFF_CHANGE_EN = 8'h0c;
  localparam logic [7:0] PBCD_OFF_ANALOG    = 8'h10;
  localparam logic [7:0] PBCD_OFF_INTCTRL   = 8'h14;
  localparam logic [7:0] PBCD_OFF_OPTION    = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PBCD_BIT_CHANGE_FLAG   = 0;
  localparam int PBCD_BIT_CHANGE_IRQ_EN = 3;
  localparam int PBCD_BIT_GLOBAL_IRQ_EN = 7;
  localparam int PBCD_BIT_PULLUP_DIS    = 7;
  localparam int PBCD_ANALOG_LSB        = 0;
  localparam int PBCD_ANALOG_PINS       = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PBCD_RST_DIRECTION = 8'hff;
  localparam logic [7:0] PBCD_RST_PULLUP    = 8'hff;
  localparam logic [7:0] PBCD_RST_CHANGE_EN = 8'h00;
  localparam logic [5:0] PBCD_RST_ANALOG    = 6'h3f;
  localparam logic [7:0] PBCD_RST_INTCTRL   = 8'h00;
  localparam logic [7:0] PBCD_RST_OPTION    = 8'hff;
  localparam logic [7:0] PBCD_RST_LATCH     = 8'h00;

  // ----------------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] PBCD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PBCD_RESP_SLVERR = 2'h2;

endpackage

// >>> pbcd_sync.sv
// Two-stage synchroniser for the eight port pin inputs.
// Assumes the pins are asynchronous to sys_clk.
module pbcd_sync
  import pbcd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } pbcd_sync_type;

  pbcd_sync_type state;
  pbcd_sync_type next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign sync_out = state.stage2;

endmodule

// >>> pbcd_pin_model.sv
// External pin model: drives the pins the port leaves as inputs.
// Assumes the bench sets the level of every undriven pin.
module pbcd_pin_model (
  input  wire logic [7:0] port_pin_out,
  input  wire logic [7:0] port_pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Pin resolution
  // --------------------------------------------------------------
  // Output pins follow the latch, inputs follow the external source
  assign pin_level = (port_pin_oe & port_pin_out)
                   | (~port_pin_oe & ext_level);
endmodule

// >>> pbcd_port_chk.sv
// Checker for pbcd_port: bus answers, pin drive and change outputs.
// Assumes it is bound into every pbcd_port instance.
module pbcd_port_chk
  import pbcd_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  port_pin_oe,
  input wire logic [7:0]  port_pullup_on,
  input wire logic [5:0]  analog_select_bits,
  input wire logic        change_irq,
  input wire logic        wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  irq_wake_a: assert property (change_irq |-> wake_request)
    else $error("change irq without wake request");
  pull_output_a: assert property ((port_pin_oe & port_pullup_on) == 8'h00)
    else $error("pull-up on a driven pin");
  reset_drive_a: assert property ($rose(reset_n) |->
    port_pin_oe == 8'h00 && port_pullup_on == 8'h00)
    else $error("pins not released after reset");
  analog_pull_a: assert property (
    (port_pullup_on[5:0] & analog_select_bits) == 6'h00)
    else $error("pull-up on an analog pin");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read upper bits not zero");
  read_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not dropped");
  write_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not dropped");
  cover property (change_irq);
  cover property (s_axi_bvalid && s_axi_bresp == PBCD_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pbcd_port pbcd_port_chk chk_u (.sys_clk, .reset_n, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .port_pin_oe, .port_pullup_on,
  .analog_select_bits, .change_irq, .wake_request);

// >>> port_b_change_detect_io_tb_top.sv
// Testbench for pbcd_port: registers, pins and change detection.
// Assumes the pin model stands for all external pin drivers.
module port_b_change_detect_io_tb_top
  import pbcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, reset_n, power_on_reset_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_level, pin_level;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, change_irq, wake_request;
  logic [7:0]  port_pin_out, port_pin_oe, port_pullup_on;
  logic [5:0]  analog_select_bits;
  logic [31:0] d;
  int          n_mismatch, cmp_count;
  pbcd_port dut_u (.sys_clk, .reset_n, .power_on_reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_pin_in(pin_level), .port_pin_out, .port_pin_oe,
    .port_pullup_on, .analog_select_bits, .change_irq, .wake_request);
  pbcd_pin_model pin_u (.port_pin_out, .port_pin_oe, .ext_level, .pin_level);
  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task wo(input logic [7:0] a, input logic [7:0] v);
    wr(a, v, r);
    chk("write response", r, PBCD_RESP_OKAY);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a, d, r);
    chk(nm, d, exp);
    chk("read response", r, PBCD_RESP_OKAY);
  endtask
  task rst(input logic full);
    reset_n <= 1'b0;
    power_on_reset_n <= !full;
    wt(3);
    reset_n <= 1'b1;
    power_on_reset_n <= 1'b1;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_reset;
    ext_level <= 8'hff;
    wt(6);
    rc("direction", PBCD_OFF_DIRECTION, 8'hff);
    rc("pullup", PBCD_OFF_PULLUP, 8'hff);
    rc("change enable", PBCD_OFF_CHANGE_EN, 8'h00);
    rc("analog", PBCD_OFF_ANALOG, 8'h3f);
    rc("option", PBCD_OFF_OPTION, 8'hff);
    rc("data", PBCD_OFF_DATA, 8'hc0);
    chk("oe", port_pin_oe, 8'h00);
    chk("pullup on", port_pullup_on, 8'h00);
    $display("test reset done");
  endtask
  task t_regs;
    wo(PBCD_OFF_ANALOG, 8'hff);
    rc("analog", PBCD_OFF_ANALOG, 8'h3f);
    chk("analog bits", analog_select_bits, 6'h3f);
    s_axi_wstrb <= 4'he;
    wo(PBCD_OFF_ANALOG, 8'h00);
    s_axi_wstrb <= 4'hf;
    rc("analog", PBCD_OFF_ANALOG, 8'h3f);
    wo(PBCD_OFF_ANALOG, 8'h00);
    wr(8'h1c, 8'h55, r);
    chk("unmapped write", r, PBCD_RESP_SLVERR);
    rd(8'h1c, d, r);
    chk("unmapped read", d, 32'h0000_0000);
    chk("unmapped resp", r, PBCD_RESP_SLVERR);
    $display("test registers done");
  endtask
  task t_pull;
    ext_level <= 8'h5a;
    wo(PBCD_OFF_DATA, 8'h3c);
    wo(PBCD_OFF_OPTION, 8'h7f);
    wo(PBCD_OFF_PULLUP, 8'ha5);
    wo(PBCD_OFF_DIRECTION, 8'h0f);
    wt(4);
    chk("oe", port_pin_oe, 8'hf0);
    chk("pin out", port_pin_out, 8'h3c);
    chk("pullup on", port_pullup_on, 8'h05);
    rc("data", PBCD_OFF_DATA, 8'h3a);
    wo(PBCD_OFF_DIRECTION, 8'hff);
    wo(PBCD_OFF_ANALOG, 8'h3f);
    wt(2);
    chk("pullup on", port_pullup_on, 8'h80);
    wo(PBCD_OFF_OPTION, 8'hff);
    wt(2);
    chk("pullup on", port_pullup_on, 8'h00);
    $display("test pull-up done");
  endtask
  task t_change;
    ext_level <= 8'h00;
    wo(PBCD_OFF_ANALOG, 8'h00);
    wo(PBCD_OFF_CHANGE_EN, 8'h81);
    wo(PBCD_OFF_INTCTRL, 8'h88);
    rc("data", PBCD_OFF_DATA, 8'h00);
    ext_level <= 8'h02;
    wt(6);
    chk("irq", change_irq, 1'b0);
    ext_level <= 8'h82;
    wt(6);
    chk("irq", change_irq, 1'b1);
    chk("wake", wake_request, 1'b1);
    wo(PBCD_OFF_INTCTRL, 8'h88);
    rc("intctrl", PBCD_OFF_INTCTRL, 8'h89);
    rc("data", PBCD_OFF_DATA, 8'h82);
    wo(PBCD_OFF_INTCTRL, 8'h88);
    rc("intctrl", PBCD_OFF_INTCTRL, 8'h88);
    chk("irq", change_irq, 1'b0);
    ext_level <= 8'h83;
    wt(6);
    wo(PBCD_OFF_INTCTRL, 8'h08);
    wt(2);
    chk("irq", change_irq, 1'b0);
    chk("wake", wake_request, 1'b1);
    wo(PBCD_OFF_ANALOG, 8'h3f);
    wo(PBCD_OFF_CHANGE_EN, 8'hff);
    rc("data", PBCD_OFF_DATA, 8'h80);
    wo(PBCD_OFF_INTCTRL, 8'h08);
    ext_level <= 8'hbc;
    wt(6);
    chk("wake", wake_request, 1'b0);
    $display("test change done");
  endtask
  task t_keep(input logic full, input logic exp);
    wo(PBCD_OFF_ANALOG, 8'h00);
    ext_level <= 8'hc3;
    wt(6);
    rc("data", PBCD_OFF_DATA, 8'hc3);
    rst(full);
    wo(PBCD_OFF_ANALOG, 8'h00);
    wo(PBCD_OFF_CHANGE_EN, 8'hff);
    wo(PBCD_OFF_INTCTRL, 8'h88);
    wt(6);
    chk("irq", change_irq, exp);
    $display("test snapshot done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Clock, sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {reset_n, power_on_reset_n, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, ext_level} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    n_mismatch = 0;
    cmp_count = 0;
    wt(3);
    reset_n <= 1'b1;
    power_on_reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_pull();
    t_change();
    t_keep(1'b0, 1'b0);
    t_keep(1'b1, 1'b1);
    summarize();
  end
  initial begin
    wt(5000);
    n_mismatch++;
    summarize();
  end
endmodule
